// >>> hdl/mhp_pkg.sv
package mhp_pkg;

  // Host-side bus widths
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;

  // Polarity configuration bits: 1 means the pin is active high
  localparam logic POL_ACK_RST = 1'h0;
  localparam logic POL_CS_RST = 1'h0;
  localparam logic POL_STRB_RST = 1'h0;
  localparam logic POL_WIDE_RST = 1'h0;
  // Direction sense: 1 means pin high is a read
  localparam logic POL_DIR_RST = 1'h1;

  // Controller register offsets (Wishbone byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;

  // CTRL field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_WIDE = 2;

  // STAT field positions
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 8;

  // Device event bits
  localparam int EV_WR = 0;
  localparam int EV_RD = 1;

  localparam logic [7:0] REG_POL = 8'h18;

endpackage

// >>> hdl/mhp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mhp_if;
  logic [8:0] host_word_addr;
  logic [15:0] data_host_o;
  logic data_host_oe;
  logic [15:0] data_dev_o;
  logic data_dev_oe;
  logic port_select;
  logic direction_sel;
  logic wide_xfer_sel;
  logic data_strobe;
  logic access_ack;
  logic irq_n;
  // Resolved bus level; device wins if both drive (a protocol error)
  logic [15:0] host_data_bus;
  assign host_data_bus = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : 16'hFFFF);

  modport dev (
    input host_word_addr, host_data_bus, port_select, direction_sel, wide_xfer_sel, data_strobe,
    output data_dev_o, data_dev_oe, access_ack, irq_n
  );
  modport host (
    input host_data_bus, access_ack, irq_n,
    output host_word_addr, data_host_o, data_host_oe, port_select, direction_sel,
    output wide_xfer_sel, data_strobe
  );
endinterface
`default_nettype wire

// >>> hdl/mhp_dev.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Interrupt output active low, idle high
// - Nine-bit word address, no byte access
// - Write acknowledged only after data stored
// - Read acknowledged once data driven
// - Acknowledge polarity configurable, reset active low
// - Access only while chip select active
// - Sixteen-bit bus, driven only on reads
// - Direction pin high reads, sense configurable
// - Wide mode pairs accesses, auto-increment address
// - Wide select polarity selectable, default low
// - Write data latched on strobe
// - Read strobe means host ready
// - Strobe polarity selectable, default low
// - No time-stamping or encryption on port
module mhp_dev #(
  parameter int DEPTH = 512
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host port
  mhp_if.dev port,
  // Polarity configuration (1 = active high / high reads)
  input wire logic pol_ack_i,
  input wire logic pol_cs_i,
  input wire logic pol_strb_i,
  input wire logic pol_wide_i,
  input wire logic pol_dir_i,
  // Interrupt source
  input wire logic irq_req_i,
  // Access events
  output logic wr_done_o,
  output logic rd_done_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_ACK} mhp_dst_t;

  typedef struct packed {
    logic [3:0] cs_s;
    logic [3:0] st_s;
    logic [3:0] dir_s;
    logic [3:0] wd_s;
    mhp_dst_t st;
    logic second;
    logic [8:0] base;
    logic ack;
    logic oe;
    logic [15:0] rdat;
    logic wr_p;
    logic rd_p;
    logic [3:0] pol_s0;
    logic [3:0] pol_s1;
  } mhp_dev_t;

  mhp_dev_t s_q, s_d;
  logic [15:0] mem_q [DEPTH];
  logic cs_a, stb_a, rd_a, wide_a, we;
  logic [8:0] eff_addr;

  // Pin level against its sense; pol = 1 means active high
  function automatic logic is_on(input logic pin, input logic pol);
    return pin ~^ pol;
  endfunction

  // Two-stage synchronisers; bit 1 = stage 2, only it is read.
  // The sense is delayed by the same two stages, so a polarity change
  // never pairs a stale pin level with the new sense.
  assign cs_a = is_on(s_q.cs_s[1], s_q.pol_s1[0]);
  assign stb_a = is_on(s_q.st_s[1], s_q.pol_s1[1]);
  assign rd_a = is_on(s_q.dir_s[1], s_q.pol_s1[3]);
  assign wide_a = is_on(s_q.wd_s[1], s_q.pol_s1[2]);
  // Second half of a wide pair goes to the next word
  assign eff_addr = s_q.second ? 9'(s_q.base + 9'h001) : port.host_word_addr;
  assign we = (s_q.st == ST_IDLE) && cs_a && stb_a && !rd_a;

  always_comb begin
    s_d = s_q;
    s_d.wr_p = 1'b0;
    s_d.rd_p = 1'b0;
    s_d.cs_s = {2'h0, s_q.cs_s[0], port.port_select};
    s_d.st_s = {2'h0, s_q.st_s[0], port.data_strobe};
    s_d.dir_s = {2'h0, s_q.dir_s[0], port.direction_sel};
    s_d.wd_s = {2'h0, s_q.wd_s[0], port.wide_xfer_sel};
    s_d.pol_s0 = {pol_dir_i, pol_wide_i, pol_strb_i, pol_cs_i};
    s_d.pol_s1 = s_q.pol_s0;
    case (s_q.st)
      ST_IDLE: begin
        // Address and data are held stable by the host while strobe is active
        if (cs_a && stb_a) begin
          if (rd_a) begin
            s_d.rdat = mem_q[eff_addr];
            s_d.oe = 1'b1;
            s_d.rd_p = 1'b1;
          end else begin
            s_d.wr_p = 1'b1;
          end
          s_d.ack = 1'b1;
          s_d.st = ST_ACK;
          if (wide_a && !s_q.second) begin
            s_d.second = 1'b1;
            s_d.base = port.host_word_addr;
          end else begin
            s_d.second = 1'b0;
          end
        end
      end
      ST_ACK: begin
        if (!cs_a || !stb_a) begin
          s_d.ack = 1'b0;
          s_d.oe = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // A deselect abandons an unfinished wide pair
    if (!cs_a) begin
      s_d.second = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      // Start at the idle pin level of the default sense: no phantom access
      s_q.cs_s <= {2'h0, ~mhp_pkg::POL_CS_RST, ~mhp_pkg::POL_CS_RST};
      s_q.st_s <= {2'h0, ~mhp_pkg::POL_STRB_RST, ~mhp_pkg::POL_STRB_RST};
      s_q.pol_s0 <= {mhp_pkg::POL_DIR_RST, mhp_pkg::POL_WIDE_RST, mhp_pkg::POL_STRB_RST,
                     mhp_pkg::POL_CS_RST};
      s_q.pol_s1 <= {mhp_pkg::POL_DIR_RST, mhp_pkg::POL_WIDE_RST, mhp_pkg::POL_STRB_RST,
                     mhp_pkg::POL_CS_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // Storage written at the same edge that raises ack, so ack means stored
  always_ff @(posedge clk_i) begin
    if (we) begin
      mem_q[eff_addr] <= port.host_data_bus;
    end
  end

  // Plain storage: no stamping or cipher stage in the path
  assign port.data_dev_o = s_q.rdat;
  assign port.data_dev_oe = s_q.oe;
  assign port.access_ack = is_on(s_q.ack, pol_ack_i);
  assign port.irq_n = ~irq_req_i;
  assign wr_done_o = s_q.wr_p;
  assign rd_done_o = s_q.rd_p;

endmodule // mhp_dev
`default_nettype wire

// >>> hdl/mhp_host.sv
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module mhp_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt
  output logic irq_o,
  // Polarity configuration for the device
  output logic pol_ack_o,
  output logic pol_cs_o,
  output logic pol_strb_o,
  output logic pol_wide_o,
  output logic pol_dir_o,
  // Host port
  mhp_if.host port
);

  typedef enum logic [2:0] {HS_IDLE, HS_STRB, HS_REL, HS_GAP} mhp_hst_t;

  typedef struct packed {
    logic [1:0] ack_s;
    logic [1:0] irq_s;
    mhp_hst_t st;
    logic [8:0] addr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic rd;
    logic wide;
    logic half;
    logic cs;
    logic strb;
    logic oe;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [4:0] pol;
    logic wb_ack;
    logic [31:0] wb_dat;
  } mhp_host_t;

  mhp_host_t s_q, s_d;
  logic ack_a, wb_req, wb_wr;
  logic [1:0] ev;

  assign ack_a = s_q.ack_s[1] ~^ s_q.pol[4];
  assign wb_req = cyc_i && stb_i && !s_q.wb_ack;
  // A write lands only at the edge where the master samples ack high
  assign wb_wr = cyc_i && stb_i && we_i && s_q.wb_ack;

  always_comb begin
    s_d = s_q;
    ev = 2'h0;
    s_d.wb_ack = 1'b0;
    s_d.ack_s = {s_q.ack_s[0], port.access_ack};
    s_d.irq_s = {s_q.irq_s[0], port.irq_n};
    case (s_q.st)
      HS_IDLE: begin
        if (s_q.cs) begin
          s_d.strb = 1'b1;
          s_d.st = HS_STRB;
        end
      end
      HS_STRB: begin
        if (ack_a) begin
          if (s_q.rd) begin
            if (s_q.half) s_d.rdat[31:16] = port.host_data_bus;
            else s_d.rdat[15:0] = port.host_data_bus;
          end
          s_d.strb = 1'b0;
          s_d.st = HS_REL;
        end
      end
      HS_REL: begin
        if (!ack_a) begin
          if (s_q.wide && !s_q.half) begin
            s_d.half = 1'b1;
            s_d.st = HS_IDLE;
          end else begin
            s_d.cs = 1'b0;
            s_d.oe = 1'b0;
            s_d.half = 1'b0;
            ev[s_q.rd ? mhp_pkg::EV_RD : mhp_pkg::EV_WR] = 1'b1;
            s_d.st = HS_GAP;
          end
        end
      end
      HS_GAP: s_d.st = HS_IDLE;
      default: s_d.st = HS_IDLE;
    endcase
    // Event set wins over a same-cycle clear
    if (wb_wr && adr_i == mhp_pkg::REG_STAT && sel_i[0]) begin
      s_d.stat = s_q.stat & ~dat_i[1:0];
    end
    s_d.stat = s_d.stat | ev;
    if (wb_wr) begin
      case (adr_i)
        mhp_pkg::REG_CTRL: begin
          if (sel_i[0] && dat_i[mhp_pkg::CTRL_GO] && !s_q.cs) begin
            s_d.rd = dat_i[mhp_pkg::CTRL_READ];
            s_d.wide = dat_i[mhp_pkg::CTRL_WIDE];
            s_d.cs = 1'b1;
            s_d.oe = !dat_i[mhp_pkg::CTRL_READ];
            s_d.half = 1'b0;
          end
        end
        mhp_pkg::REG_ADDR: if (!s_q.cs) s_d.addr = dat_i[8:0];
        mhp_pkg::REG_WDATA: if (!s_q.cs) s_d.wdat = dat_i;
        mhp_pkg::REG_MASK: s_d.mask = dat_i[1:0];
        mhp_pkg::REG_POL: if (!s_q.cs) s_d.pol = dat_i[4:0];
        default: s_d.wb_dat = 32'h0;
      endcase
    end
    if (wb_req) begin
      s_d.wb_ack = 1'b1;
      s_d.wb_dat = 32'h0;
      if (!we_i) begin
        case (adr_i)
          mhp_pkg::REG_CTRL: s_d.wb_dat = {29'h0, s_q.wide, s_q.rd, s_q.cs};
          mhp_pkg::REG_ADDR: s_d.wb_dat = {23'h0, s_q.addr};
          mhp_pkg::REG_WDATA: s_d.wb_dat = s_q.wdat;
          mhp_pkg::REG_RDATA: s_d.wb_dat = s_q.rdat;
          mhp_pkg::REG_STAT: s_d.wb_dat = {23'h0, s_q.cs, 5'h0, !s_q.irq_s[1], s_q.stat};
          mhp_pkg::REG_MASK: s_d.wb_dat = {30'h0, s_q.mask};
          mhp_pkg::REG_POL: s_d.wb_dat = {27'h0, s_q.pol};
          default: s_d.wb_dat = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= HS_IDLE;
      s_q.ack_s <= 2'h3;
      s_q.irq_s <= 2'h3;
      s_q.pol <= {mhp_pkg::POL_ACK_RST, mhp_pkg::POL_DIR_RST, mhp_pkg::POL_WIDE_RST,
                  mhp_pkg::POL_STRB_RST, mhp_pkg::POL_CS_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign pol_cs_o = s_q.pol[0];
  assign pol_strb_o = s_q.pol[1];
  assign pol_wide_o = s_q.pol[2];
  assign pol_dir_o = s_q.pol[3];
  assign pol_ack_o = s_q.pol[4];
  assign port.host_word_addr = s_q.addr;
  assign port.port_select = s_q.cs ~^ s_q.pol[0];
  assign port.data_strobe = s_q.strb ~^ s_q.pol[1];
  assign port.wide_xfer_sel = s_q.wide ~^ s_q.pol[2];
  assign port.direction_sel = s_q.rd ~^ s_q.pol[3];
  assign port.data_host_o = s_q.half ? s_q.wdat[31:16] : s_q.wdat[15:0];
  assign port.data_host_oe = s_q.oe;
  assign dat_o = s_q.wb_dat;
  assign ack_o = s_q.wb_ack;
  assign irq_o = |(s_q.stat & s_q.mask);

endmodule // mhp_host
`default_nettype wire

// >>> dv/mhp_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module mhp_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic port_select,
  input wire logic direction_sel,
  input wire logic data_strobe,
  input wire logic access_ack,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  // Configured senses (1 = active high / high reads)
  input wire logic pol_cs,
  input wire logic pol_strb,
  input wire logic pol_ack,
  input wire logic pol_dir
);
  logic sel_on, stb_on, ack_on, rd_on;
  // Pins and senses change on the same edge, so these never glitch
  assign sel_on = port_select ~^ pol_cs;
  assign stb_on = data_strobe ~^ pol_strb;
  assign ack_on = access_ack ~^ pol_ack;
  assign rd_on = direction_sel ~^ pol_dir;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence strb_start;
    $rose(stb_on) ##1 stb_on;
  endsequence
  sequence ack_idle;
    !ack_on [*3];
  endsequence
  chk_ack_needs_sel: assert property (ack_on |-> sel_on)
    else $error("ack without select");
  chk_ack_bounded: assert property (strb_start |-> ##[0:8] ack_on)
    else $error("ack too late");
  chk_ack_idle_sel: assert property ($fell(sel_on) |-> ack_idle)
    else $error("ack after deselect");
  chk_ack_release: assert property ($fell(stb_on) |-> ##[0:4] !ack_on)
    else $error("ack held");
  chk_ack_synced: assert property ($rose(ack_on) |-> $past(stb_on, 3))
    else $error("ack before sync");
  chk_dev_drive_read: assert property (data_dev_oe |-> rd_on && !data_host_oe)
    else $error("device drives on write");
  chk_read_ack_data: assert property ($rose(ack_on) && rd_on |-> data_dev_oe)
    else $error("read ack without data");
  chk_write_ack_data: assert property ($rose(ack_on) && !rd_on |-> data_host_oe)
    else $error("write ack without data");
endmodule // mhp_asserts
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i, rst_i, cyc, stb, we, irq_req, ack_o, irq_o;
  logic pa, pc, ps, pw, pd, wr_done, rd_done;
  int cnt_wr = 0;
  int cnt_rd = 0;
  int want_wr = 0;
  int want_rd = 0;
  logic [7:0] adr;
  logic [8:0] a;
  logic [31:0] wdat, dat_o, q, d;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 85476;
  logic [15:0] mem [512];
  mhp_if u_mhp_if ();
  mhp_dev u_mhp_dev (.clk_i(clk_i), .rst_i(rst_i), .port(u_mhp_if), .pol_ack_i(pa),
    .pol_cs_i(pc), .pol_strb_i(ps), .pol_wide_i(pw), .pol_dir_i(pd), .irq_req_i(irq_req),
    .wr_done_o(wr_done), .rd_done_o(rd_done));
  mhp_host u_mhp_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .pol_ack_o(pa), .pol_cs_o(pc), .pol_strb_o(ps), .pol_wide_o(pw), .pol_dir_o(pd),
    .port(u_mhp_if));
  mhp_asserts u_mhp_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .port_select(u_mhp_if.port_select), .direction_sel(u_mhp_if.direction_sel),
    .data_strobe(u_mhp_if.data_strobe), .access_ack(u_mhp_if.access_ack),
    .data_host_oe(u_mhp_if.data_host_oe), .data_dev_oe(u_mhp_if.data_dev_oe),
    .pol_cs(pc), .pol_strb(ps), .pol_ack(pa), .pol_dir(pd));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task summarize;
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The request stands until an edge samples ack high; read data is taken there
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= dt;
    do @(posedge clk_i);
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function logic [31:0] ctrl_word(input logic rd, input logic wide);
    return (32'h1 << mhp_pkg::CTRL_GO) | ({31'h0, rd} << mhp_pkg::CTRL_READ)
      | ({31'h0, wide} << mhp_pkg::CTRL_WIDE);
  endfunction
  function logic [31:0] exp_rd(input logic wide, input logic [8:0] ad);
    return {wide ? mem[ad + 9'h1] : 16'h0, mem[ad]};
  endfunction
  task xfer(input logic rd, input logic wide, input logic [8:0] ad, input logic [31:0] dt);
    wb(1'b1, mhp_pkg::REG_ADDR, {23'h0, ad});
    if (rd) want_rd += wide ? 2 : 1;
    else want_wr += wide ? 2 : 1;
    if (!rd) begin
      wb(1'b1, mhp_pkg::REG_WDATA, dt);
      mem[ad] = dt[15:0];
      if (wide) mem[ad + 9'h1] = dt[31:16];
    end
    wb(1'b1, mhp_pkg::REG_CTRL, ctrl_word(rd, wide));
    do wb(1'b0, mhp_pkg::REG_STAT, 32'h0);
    while (q[mhp_pkg::STAT_BUSY] !== 1'b0 || q[1:0] === 2'h0);
    chk({30'h0, q[1:0]}, 32'h1 << rd);
    // Mask enables only the write event
    chk({31'h0, irq_o}, {31'h0, !rd});
    if (rd) begin
      wb(1'b0, mhp_pkg::REG_RDATA, 32'h0);
      chk(q & (wide ? 32'hFFFFFFFF : 32'h0000FFFF), exp_rd(wide, ad));
    end
    wb(1'b1, mhp_pkg::REG_STAT, 32'h3);
    wb(1'b0, mhp_pkg::REG_STAT, 32'h0);
    chk({29'h0, q[1:0], irq_o}, 32'h0);
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (wr_done === 1'b1) cnt_wr <= cnt_wr + 1;
    if (rd_done === 1'b1) cnt_rd <= cnt_rd + 1;
    if (cycles == 8000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    irq_req = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, mhp_pkg::REG_POL, 32'h0);
    chk(q, 32'h8);
    chk({30'h0, u_mhp_if.port_select, u_mhp_if.access_ack}, 32'h3);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, mhp_pkg::REG_MASK, 32'h1);
    chk({31'h0, u_mhp_if.irq_n}, 32'h1);
    irq_req <= 1'b1;
    // Let the interrupt pass the host's two-stage synchroniser
    repeat (2) @(posedge clk_i);
    wb(1'b0, mhp_pkg::REG_STAT, 32'h0);
    chk({q[2], u_mhp_if.irq_n}, 32'h2);
    irq_req <= 1'b0;
    xfer(1'b0, 1'b0, 9'h000, 32'h0000A55A);
    xfer(1'b0, 1'b0, 9'h1FF, 32'h00005AA5);
    xfer(1'b1, 1'b0, 9'h000, 32'h0);
    xfer(1'b1, 1'b0, 9'h1FF, 32'h0);
    xfer(1'b0, 1'b1, 9'h1FE, 32'h1234ABCD);
    xfer(1'b1, 1'b0, 9'h1FF, 32'h0);
    xfer(1'b1, 1'b1, 9'h1FE, 32'h0);
    for (int i = 0; i < 6; i++) begin
      a = 9'($random(seed));
      d = $random(seed);
      if (a > 9'h1FD) a = 9'h010;
      xfer(1'b0, i[0], a, d);
      xfer(1'b1, i[0], a, 32'h0);
    end
    // Select, strobe, wide and ack active high, direction low reads
    wb(1'b1, mhp_pkg::REG_POL, 32'h17);
    wb(1'b0, mhp_pkg::REG_POL, 32'h0);
    chk(q, 32'h17);
    chk({29'h0, u_mhp_if.port_select, u_mhp_if.access_ack, u_mhp_if.data_strobe}, 32'h0);
    xfer(1'b0, 1'b1, 9'h020, 32'hC3A55A3C);
    xfer(1'b1, 1'b1, 9'h020, 32'h0);
    chk(cnt_wr, want_wr);
    chk(cnt_rd, want_rd);
    summarize;
  end
endmodule // testbench
`default_nettype wire
